// ### rtl/ssia_link_lamp.sv
// One port link/activity lamp driver.
// Assumes link and activity inputs already synchronised to pclk.
module ssia_link_lamp
  import ssia_pkg::*;
(
  // Port status
  input wire logic link_up,
  input wire logic activity,
  // Pattern source
  input wire logic flicker,
  // Lamp
  output logic lamp
);

  // Traffic only counts on an established link
  assign lamp = link_up & (activity ? flicker : 1'b1);

endmodule

// ### rtl/ssia_pattern_gen.sv
// Free-running lamp pattern generator: blink, single flash, flicker.
// Assumes a clock enable that freezes the counters while low.
module ssia_pattern_gen
  import ssia_pkg::*;
#(
  parameter int BLINK_HALF = BLINK_HALF_CYC,
  parameter int FLASH_ON = FLASH_ON_CYC,
  parameter int FLASH_OFF = FLASH_OFF_CYC,
  parameter int FLICK_HALF = FLICK_HALF_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Patterns
  output logic blink,
  output logic flash,
  output logic flicker
);

  logic [24:0] blink_cnt_ff;
  logic [25:0] flash_cnt_ff;
  logic [24:0] flick_cnt_ff;
  logic blink_ff;
  logic flash_ff;
  logic flick_ff;
  logic blink_wrap;
  logic flash_wrap;
  logic flick_wrap;

  assign blink_wrap = blink_cnt_ff == 25'(BLINK_HALF - 1);
  assign flick_wrap = flick_cnt_ff == 25'(FLICK_HALF - 1);
  assign flash_wrap = flash_ff ? flash_cnt_ff == 26'(FLASH_ON - 1)
                               : flash_cnt_ff == 26'(FLASH_OFF - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_ff <= '0;
      flash_cnt_ff <= '0;
      flick_cnt_ff <= '0;
      blink_ff <= 1'b0;
      flash_ff <= 1'b0;
      flick_ff <= 1'b0;
    end else if (clk_en) begin
      blink_cnt_ff <= blink_wrap ? '0 : blink_cnt_ff + 25'h1;
      flick_cnt_ff <= flick_wrap ? '0 : flick_cnt_ff + 25'h1;
      flash_cnt_ff <= flash_wrap ? '0 : flash_cnt_ff + 26'h1;
      if (blink_wrap) blink_ff <= ~blink_ff;
      if (flick_wrap) flick_ff <= ~flick_ff;
      if (flash_wrap) flash_ff <= ~flash_ff;
    end
  end

  assign blink = blink_ff;
  assign flash = flash_ff;
  assign flicker = flick_ff;

endmodule

// ### rtl/ssia_top.sv
// Status lamps, node-address capture and sensor numbering with an APB
// register file. Assumes pins arrive asynchronous to pclk.
//
// Our own choices: register access over APB and the address map.
module ssia_top
  import ssia_pkg::*;
#(
  parameter int BLINK_HALF = BLINK_HALF_CYC,
  parameter int FLASH_ON = FLASH_ON_CYC,
  parameter int FLASH_OFF = FLASH_OFF_CYC,
  parameter int FLICK_HALF = FLICK_HALF_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic unit_power,
  input wire logic link_in_up,
  input wire logic link_in_act,
  input wire logic link_out_up,
  input wire logic link_out_act,
  input wire ssia_switch_t node_switch,
  input wire logic dup_addr_det,
  input wire logic [4:0] local_amps,
  input wire logic [31:0] exp_amps,
  // Status out
  output ssia_lamps_t lamps,
  output logic [9:0] node_addr,
  output logic addr_from_tool,
  output logic op_halt
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_W = 5 + 12 + 1 + 5 + 32;
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  logic [SYNC_W-1:0] pins_raw;

  assign pins_raw = {unit_power, link_in_up, link_in_act, link_out_up,
                     link_out_act, node_switch, dup_addr_det, local_amps,
                     exp_amps};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else if (clk_en) begin
      sync1_ff <= pins_raw;
      sync2_ff <= sync1_ff;
    end
  end

  logic s_power;
  logic s_in_up;
  logic s_in_act;
  logic s_out_up;
  logic s_out_act;
  ssia_switch_t s_sw;
  logic s_dup;
  logic [4:0] s_local;
  logic [31:0] s_exp;

  assign {s_power, s_in_up, s_in_act, s_out_up, s_out_act, s_sw, s_dup,
          s_local, s_exp} = sync2_ff;

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  logic [31:0] ctrl_ff;
  logic [31:0] nxt_ctrl;
  logic wr_en;
  logic rd_hit;
  logic sel_ctrl;
  logic sel_stat;
  logic sel_addr;
  logic sel_unit;
  logic sel_amp;
  logic [31:0] rd_mux;

  assign sel_ctrl = paddr == SSIA_CTRL_OFS;
  assign sel_stat = paddr == SSIA_STAT_OFS;
  assign sel_addr = paddr == SSIA_ADDR_OFS;
  assign sel_unit = paddr == SSIA_UNIT_OFS;
  assign sel_amp = paddr == SSIA_AMP_OFS;
  assign rd_hit = sel_ctrl | sel_stat | sel_addr | sel_unit | sel_amp;
  assign wr_en = psel & penable & pwrite & sel_ctrl & clk_en;
  // Zero-wait slave; unmapped addresses error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~rd_hit;
  // Self-clearing duplicate-clear strobe bit never stores
  assign nxt_ctrl = pwdata & ~(32'h1 << CTRL_DUPCLR_BIT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RST;
    end else if (wr_en) begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  ssia_comm_t comm_state;
  logic set_err;
  logic sync_err;
  logic boot_err;
  logic wdog_to;
  logic tool_mode;
  logic sens_ok;
  logic sens_err;
  logic [9:0] tool_addr;
  logic dup_clr;

  assign comm_state = ssia_comm_t'(ctrl_ff[CTRL_STATE_LSB +: 2]);
  assign set_err = ctrl_ff[CTRL_SETERR_BIT];
  assign sync_err = ctrl_ff[CTRL_SYNCERR_BIT];
  assign boot_err = ctrl_ff[CTRL_BOOTERR_BIT];
  assign wdog_to = ctrl_ff[CTRL_WDOG_BIT];
  assign tool_mode = ctrl_ff[CTRL_TOOLADDR_BIT];
  assign sens_ok = ctrl_ff[CTRL_SENSOK_BIT];
  assign sens_err = ctrl_ff[CTRL_SENSERR_BIT];
  assign tool_addr = ctrl_ff[CTRL_TOOLVAL_LSB +: 10];
  assign dup_clr = wr_en & pwdata[CTRL_DUPCLR_BIT];

  // ----------------------------------------------------------------
  // Node address capture
  // ----------------------------------------------------------------
  logic [1:0] settle_ff;
  logic latched_ff;
  logic [9:0] sw_addr_ff;
  logic [9:0] sw_dec;
  logic capture;
  logic bad_sw;
  logic sw_zero;

  assign sw_dec = 10'(s_sw.hund * WEIGHT_HUND)
                + 10'(s_sw.tens * WEIGHT_TENS)
                + 10'(s_sw.ones);
  // Wait for the synchroniser to fill before capture
  assign capture = clk_en & ~latched_ff & (settle_ff == 2'h3);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_ff <= 2'h0;
      latched_ff <= 1'b0;
      sw_addr_ff <= NODE_ADDR_DEFAULT;
    end else if (clk_en) begin
      if (settle_ff != 2'h3) settle_ff <= settle_ff + 2'h1;
      if (capture) begin
        latched_ff <= 1'b1;
        sw_addr_ff <= sw_dec;
      end
    end
  end

  assign sw_zero = sw_addr_ff == NODE_ADDR_DEFAULT;
  // 998/999 is an installer fault; flagged, never used
  assign bad_sw = latched_ff & (sw_addr_ff > NODE_ADDR_MAX);
  assign addr_from_tool = sw_zero | tool_mode;

  logic [9:0] nxt_node_addr;
  logic [9:0] node_addr_ff;

  assign nxt_node_addr = addr_from_tool ? tool_addr
                       : bad_sw ? NODE_ADDR_DEFAULT
                       : sw_addr_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      node_addr_ff <= NODE_ADDR_DEFAULT;
    end else if (clk_en) begin
      node_addr_ff <= nxt_node_addr;
    end
  end

  assign node_addr = node_addr_ff;

  // ----------------------------------------------------------------
  // Duplicate address: sticky, set wins over clear
  // ----------------------------------------------------------------
  logic dup_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dup_ff <= 1'b0;
    end else if (clk_en) begin
      dup_ff <= s_dup | (dup_ff & ~dup_clr);
    end
  end

  assign op_halt = dup_ff | bad_sw;

  // ----------------------------------------------------------------
  // Sensor unit numbering
  // ----------------------------------------------------------------
  // Eight bits so an over-full chain cannot wrap below the cap
  logic [7:0] exp_cnt [MAX_EXP];
  logic [7:0] first_num [MAX_EXP + 1];
  logic [7:0] total_raw;
  logic [4:0] amp_total;

  assign first_num[0] = {3'h0, FIRST_UNIT_NUM};
  assign first_num[1] = first_num[0] + {3'h0, s_local};

  genvar gi;
  generate
    for (gi = 0; gi < MAX_EXP; gi++) begin : g_exp
      assign exp_cnt[gi] = {4'h0, s_exp[gi*EXP_CNT_W +: EXP_CNT_W]};
    end
    for (gi = 1; gi < MAX_EXP; gi++) begin : g_num
      assign first_num[gi+1] = first_num[gi] + exp_cnt[gi-1];
    end
  endgenerate

  // Units on the last expansion close the running count
  assign total_raw = first_num[MAX_EXP] + exp_cnt[MAX_EXP-1] - 8'h01;
  // Excess amplifiers beyond the cap are not numbered
  assign amp_total = (total_raw > 8'(MAX_AMPS)) ? 5'(MAX_AMPS)
                   : total_raw[4:0];

  logic [4:0] amp_total_ff;
  logic amp_over_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_total_ff <= 5'h00;
      amp_over_ff <= 1'b0;
    end else if (clk_en) begin
      amp_total_ff <= amp_total;
      amp_over_ff <= total_raw > 8'(MAX_AMPS);
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [31:0] stat_word;
  logic [31:0] first_word;

  assign stat_word = {27'h0, addr_from_tool, latched_ff, bad_sw,
                      op_halt, dup_ff};
  // First unit number of expansion units 0 to 5, low five bits each
  assign first_word = {1'b0, amp_over_ff, first_num[6][4:0],
                       first_num[5][4:0], first_num[4][4:0],
                       first_num[3][4:0], first_num[2][4:0],
                       first_num[1][4:0]};
  assign rd_mux = sel_ctrl ? ctrl_ff
                : sel_stat ? stat_word
                : sel_addr ? {22'h0, node_addr_ff}
                : sel_unit ? first_word
                : sel_amp ? {27'h0, amp_total_ff}
                : 32'h0000_0000;

  logic [31:0] prdata_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      prdata_ff <= rd_mux;
    end
  end

  assign prdata = prdata_ff;

  // ----------------------------------------------------------------
  // Lamps
  // ----------------------------------------------------------------
  logic pat_blink;
  logic pat_flash;
  logic pat_flick;

  ssia_pattern_gen #(
    .BLINK_HALF(BLINK_HALF),
    .FLASH_ON(FLASH_ON),
    .FLASH_OFF(FLASH_OFF),
    .FLICK_HALF(FLICK_HALF)
  ) u_pat (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .blink(pat_blink),
    .flash(pat_flash),
    .flicker(pat_flick)
  );

  logic lamp_in;
  logic lamp_out;

  ssia_link_lamp u_link_in (
    .link_up(s_in_up),
    .activity(s_in_act),
    .flicker(pat_flick),
    .lamp(lamp_in)
  );

  ssia_link_lamp u_link_out (
    .link_up(s_out_up),
    .activity(s_out_act),
    .flicker(pat_flick),
    .lamp(lamp_out)
  );

  ssia_pat_t state_pat;
  ssia_pat_t fault_pat;
  logic state_lamp;
  logic fault_lamp;

  always_comb begin
    case (comm_state)
      SSIA_ST_INIT: state_pat = SSIA_PAT_OFF;
      SSIA_ST_PREOP: state_pat = SSIA_PAT_BLINK;
      SSIA_ST_SAFEOP: state_pat = SSIA_PAT_FLASH;
      SSIA_ST_OP: state_pat = SSIA_PAT_ON;
      default: state_pat = SSIA_PAT_OFF;
    endcase
  end

  // Most severe fault wins
  assign fault_pat = wdog_to ? SSIA_PAT_ON
                   : boot_err ? SSIA_PAT_FLICK
                   : sync_err ? SSIA_PAT_FLASH
                   : set_err ? SSIA_PAT_BLINK
                   : SSIA_PAT_OFF;

  function automatic logic pat_level(input ssia_pat_t p, input logic b,
                                     input logic f, input logic k);
    case (p)
      SSIA_PAT_ON: pat_level = 1'b1;
      SSIA_PAT_BLINK: pat_level = b;
      SSIA_PAT_FLASH: pat_level = f;
      SSIA_PAT_FLICK: pat_level = k;
      default: pat_level = 1'b0;
    endcase
  endfunction

  assign state_lamp = pat_level(state_pat, pat_blink, pat_flash, pat_flick);
  assign fault_lamp = pat_level(fault_pat, pat_blink, pat_flash, pat_flick);

  ssia_lamps_t nxt_lamps;
  ssia_lamps_t lamps_ff;

  always_comb begin
    nxt_lamps.power = s_power;
    nxt_lamps.link_in = s_power & lamp_in;
    nxt_lamps.link_out = s_power & lamp_out;
    nxt_lamps.state = s_power & state_lamp;
    nxt_lamps.fault = s_power & fault_lamp;
    // Red overrides green; dark until software reports a result
    nxt_lamps.sens_red = s_power & sens_err;
    nxt_lamps.sens_green = s_power & sens_ok & ~sens_err;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamps_ff <= '0;
    end else if (clk_en) begin
      lamps_ff <= nxt_lamps;
    end
  end

  assign lamps = lamps_ff;

endmodule

// ### shared/ssia_pkg.sv
// Constants, register map and carrier types for the slave status
// indicator and node-address block.
// Assumes a 25 MHz pclk and an APB master with 32-bit data.
package ssia_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] SSIA_CTRL_OFS = 12'h000;
  localparam logic [11:0] SSIA_STAT_OFS = 12'h004;
  localparam logic [11:0] SSIA_ADDR_OFS = 12'h008;
  localparam logic [11:0] SSIA_UNIT_OFS = 12'h00C;
  localparam logic [11:0] SSIA_AMP_OFS = 12'h010;

  // CTRL fields
  localparam int CTRL_STATE_LSB = 0;     // 2-bit comm state
  localparam int CTRL_SETERR_BIT = 2;
  localparam int CTRL_SYNCERR_BIT = 3;
  localparam int CTRL_BOOTERR_BIT = 4;
  localparam int CTRL_WDOG_BIT = 5;
  localparam int CTRL_DUPCLR_BIT = 6;    // write 1 clears duplicate flag
  localparam int CTRL_TOOLADDR_BIT = 7;  // master assigns by tool
  localparam int CTRL_SENSOK_BIT = 8;
  localparam int CTRL_SENSERR_BIT = 9;
  localparam int CTRL_TOOLVAL_LSB = 16;  // 10-bit tool address
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // STAT fields
  localparam int STAT_DUP_BIT = 0;
  localparam int STAT_HALT_BIT = 1;
  localparam int STAT_BADSW_BIT = 2;
  localparam int STAT_LATCHED_BIT = 3;
  localparam int STAT_FROMTOOL_BIT = 4;

  // Amplifier count pins: local count [4:0], expansion counts 8 x 4 bits
  localparam int UNIT_LOCAL_W = 5;
  localparam int EXP_CNT_W = 4;

  // ----------------------------------------------------------------
  // Node address and sensor limits
  // ----------------------------------------------------------------
  localparam logic [9:0] NODE_ADDR_DEFAULT = 10'h000;
  localparam logic [9:0] NODE_ADDR_MAX = 10'h3E5;   // 997
  localparam logic [9:0] WEIGHT_HUND = 10'h064;     // 100
  localparam logic [9:0] WEIGHT_TENS = 10'h00A;     // 10
  localparam int MAX_AMPS = 30;
  localparam int MAX_EXP = 8;
  localparam logic [4:0] FIRST_UNIT_NUM = 5'h01;

  // ----------------------------------------------------------------
  // Lamp timing (periods in ms / half periods)
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int BLINK_HALF_MS = 200;
  localparam int FLASH_ON_MS = 200;
  localparam int FLASH_OFF_MS = 1000;
  localparam int FLICK_HALF_MS = 50;
  localparam int BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
  localparam int FLASH_ON_CYC = CLK_HZ / 1000 * FLASH_ON_MS;
  localparam int FLASH_OFF_CYC = CLK_HZ / 1000 * FLASH_OFF_MS;
  localparam int FLICK_HALF_CYC = CLK_HZ / 1000 * FLICK_HALF_MS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SSIA_ST_INIT,
    SSIA_ST_PREOP,
    SSIA_ST_SAFEOP,
    SSIA_ST_OP
  } ssia_comm_t;

  typedef enum logic [2:0] {
    SSIA_PAT_OFF,
    SSIA_PAT_ON,
    SSIA_PAT_BLINK,
    SSIA_PAT_FLASH,
    SSIA_PAT_FLICK
  } ssia_pat_t;

  typedef struct packed {
    logic power;
    logic link_in;
    logic link_out;
    logic state;
    logic fault;
    logic sens_green;
    logic sens_red;
  } ssia_lamps_t;

  typedef struct packed {
    logic [3:0] hund;
    logic [3:0] tens;
    logic [3:0] ones;
  } ssia_switch_t;

endpackage

// ### verif/ssia_chk.sv
// Concurrent checks on the status lamp and node-address block.
// Sees only the top-level ports; attached by the bind at the foot.
module ssia_chk
  import ssia_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and status
  input wire logic unit_power,
  input wire logic link_in_up,
  input wire logic link_in_act,
  input wire logic link_out_up,
  input wire logic link_out_act,
  input wire logic dup_addr_det,
  input wire ssia_lamps_t lamps,
  input wire logic [9:0] node_addr,
  input wire logic addr_from_tool,
  input wire logic op_halt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic ok;
  // Pins take three enabled edges to a lamp; wait eight to be safe
  assign nxt_cnt = !clk_en ? 4'h0 : cnt_ff + {3'h0, cnt_ff != 4'h8};
  assign ok = cnt_ff == 4'h8;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cnt_ff <= 4'h0;
    else
      cnt_ff <= nxt_cnt;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_dup_held;
    (ok && dup_addr_det) [*4];
  endsequence
  chk_power_lamp: assert property (
    ok |-> lamps.power == $past(unit_power, 3))
    else $error("power lamp does not follow unit power");
  chk_link_in: assert property (
    ok && $past(unit_power, 3) && !$past(link_in_act, 3)
    |-> lamps.link_in == $past(link_in_up, 3))
    else $error("input link lamp wrong");
  chk_link_out: assert property (
    ok && $past(unit_power, 3) && !$past(link_out_act, 3)
    |-> lamps.link_out == $past(link_out_up, 3))
    else $error("output link lamp wrong");
  chk_dark_unpowered: assert property (
    ok && !$past(unit_power, 3) |-> lamps == '0)
    else $error("lamp lit without unit power");
  chk_sens_colour: assert property (
    !(lamps.sens_green && lamps.sens_red))
    else $error("sensor lamp both colours");
  chk_ready_now: assert property (psel && penable |-> pready)
    else $error("access phase not ready");
  chk_err_phase: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  chk_err_unmapped: assert property (
    psel && penable && paddr > 12'h010 |-> pslverr)
    else $error("unmapped access without error");
  chk_ok_mapped: assert property (
    psel && penable && paddr[1:0] == 2'h0 && paddr <= 12'h010 |-> !pslverr)
    else $error("mapped access flagged");
  chk_dup_halt: assert property (
    s_dup_held |-> ##[0:2] op_halt)
    else $error("duplicate address did not halt");
  chk_addr_hold: assert property (
    ok && !addr_from_tool && !$past(addr_from_tool)
    && !$past(addr_from_tool, 2) |-> $stable(node_addr))
    else $error("switch address changed after capture");
endmodule

bind ssia_top ssia_chk u_chk (.pclk, .presetn, .clk_en, .psel, .penable,
  .paddr, .pready, .pslverr, .unit_power, .link_in_up, .link_in_act,
  .link_out_up, .link_out_act, .dup_addr_det, .lamps, .node_addr,
  .addr_from_tool, .op_halt);

// ### verif/ssia_fbm_model.sv
// Fieldbus master stand-in: raises port links and traffic on command.
// Assumes the bench drives its commands just after a pclk rising edge.
module ssia_fbm_model (
  // Clock
  input wire logic pclk,
  // Bench commands {in_up, in_busy, out_up, out_busy}
  input wire logic [3:0] cmd,
  input wire logic dup_cmd,
  // Pins toward the block
  output logic link_in_up = 1'b0,
  output logic link_in_act = 1'b0,
  output logic link_out_up = 1'b0,
  output logic link_out_act = 1'b0,
  output logic dup_addr_det = 1'b0,
  output logic [9:0] tool_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary address handed out by the configuration tool
  assign tool_addr = 10'h02A;
  // Traffic only ever runs on an established link
  always @(posedge pclk) begin
    link_in_up <= cmd[3];
    link_in_act <= cmd[3] & cmd[2];
    link_out_up <= cmd[1];
    link_out_act <= cmd[1] & cmd[0];
    dup_addr_det <= dup_cmd;
  end
endmodule

// ### verif/testbench.sv
// Self-checking bench: lamp table, address capture, numbering, APB.
// Assumes short lamp pattern parameters so 24 cycles span every period.
module testbench
  import ssia_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int F0 = 0, F1 = 768, FK = 396, BK = 390, FS = 196;
  typedef struct {logic [4:0] pins; logic [9:0] ctrl; int ex[7];} ssia_row_t;
  ssia_row_t rows[9] = '{
    '{5'h0F, 10'h103, '{F0, F0, F0, F0, F0, F0, F0}},
    '{5'h10, 10'h000, '{F1, F0, F0, F0, F0, F0, F0}},
    '{5'h18, 10'h101, '{F1, F1, F0, BK, F0, F1, F0}},
    '{5'h1E, 10'h006, '{F1, FK, F1, FS, BK, F0, F0}},
    '{5'h13, 10'h00B, '{F1, F0, FK, F1, FS, F0, F0}},
    '{5'h10, 10'h313, '{F1, F0, F0, F1, FK, F0, F1}},
    '{5'h10, 10'h03C, '{F1, F0, F0, F0, F1, F0, F0}},
    '{5'h10, 10'h01C, '{F1, F0, F0, F0, FK, F0, F0}},
    '{5'h10, 10'h00C, '{F1, F0, F0, F0, FS, F0, F0}}};
  logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, unit_power = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r32, u;
  logic pready, pslverr, er, dup_cmd = 1'b0, addr_from_tool, op_halt;
  logic link_in_up, link_in_act, link_out_up, link_out_act, dup_addr_det;
  logic [3:0] cmd = 4'h0;
  ssia_switch_t node_switch = 12'h123;
  logic [4:0] local_amps = 5'h00;
  logic [31:0] exp_amps = 32'h0000_0000, cd[7];
  ssia_lamps_t lamps;
  logic [9:0] node_addr, tool_addr;
  int failures = 0, n_tests = 0, f;

  ssia_top #(.BLINK_HALF(4), .FLASH_ON(3), .FLASH_OFF(9), .FLICK_HALF(2))
    u_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .unit_power, .link_in_up,
    .link_in_act, .link_out_up, .link_out_act, .node_switch, .dup_addr_det,
    .local_amps, .exp_amps, .lamps, .node_addr, .addr_from_tool, .op_halt);
  ssia_fbm_model u_fbm (.pclk, .cmd, .dup_cmd, .link_in_up, .link_in_act,
    .link_out_up, .link_out_act, .dup_addr_det, .tool_addr);

  initial forever #20 pclk = ~pclk;

  // ----
  // Tasks
  // ----
  task automatic results;
    $display("counts: %0d checks, %0d mismatches", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      failures++;
      results;
    end
    r32 = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Free-running patterns: 24 samples hold whole periods of each
  task automatic meas;
    int on[7];
    int tg[7];
    logic [6:0] p;
    on = '{default: 0};
    tg = '{default: 0};
    @(negedge pclk);
    p = lamps;
    repeat (24) begin
      @(negedge pclk);
      for (int k = 0; k < 7; k++) begin
        on[k] += int'(lamps[6-k]);
        tg[k] += int'(lamps[6-k] !== p[6-k]);
      end
      p = lamps;
    end
    for (int k = 0; k < 7; k++)
      cd[k] = 32'(on[k] * 32 + tg[k]);
  endtask
  task automatic do_reset(input ssia_switch_t sw);
    presetn <= 1'b0;
    node_switch <= sw;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask

  initial begin
    repeat (100000) @(posedge pclk);
    failures++;
    results;
  end

  // ----
  // Main sequence
  // ----
  initial begin
    do_reset(12'h123);
    apb(1'b0, SSIA_CTRL_OFS, 32'h0000_0000);
    chk("ctrl_rst", CTRL_RST, r32);
    chk("sw_addr", 32'h0000_007B, {22'h0, node_addr});
    chk1("from_tool", 1'b0, addr_from_tool);
    node_switch <= 12'h456;
    repeat (10) @(posedge pclk);
    apb(1'b0, SSIA_ADDR_OFS, 32'h0000_0000);
    chk("addr_held", 32'h0000_007B, r32);
    $display("test address done");
    for (int i = 0; i < 9; i++) begin
      unit_power <= rows[i].pins[4];
      cmd <= rows[i].pins[3:0];
      apb(1'b1, SSIA_CTRL_OFS, {22'h0, rows[i].ctrl});
      repeat (8) @(posedge pclk);
      meas;
      for (int k = 0; k < 7; k++)
        chk($sformatf("lamp%0d_row%0d", k, i), rows[i].ex[k], cd[k]);
    end
    $display("test lamps done");
    apb(1'b1, SSIA_CTRL_OFS, {6'h00, tool_addr, 16'h0080});
    repeat (4) @(posedge pclk);
    chk("tool_addr", {22'h0, tool_addr}, {22'h0, node_addr});
    chk1("tool_sel", 1'b1, addr_from_tool);
    dup_cmd <= 1'b1;
    repeat (8) @(posedge pclk);
    chk1("dup_halt", 1'b1, op_halt);
    apb(1'b0, SSIA_STAT_OFS, 32'h0000_0000);
    chk1("dup_flag", 1'b1, r32[STAT_DUP_BIT]);
    dup_cmd <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b1, SSIA_CTRL_OFS, 32'h0000_0040);
    repeat (2) @(posedge pclk);
    chk1("dup_clear", 1'b0, op_halt);
    clk_en <= 1'b0;
    apb(1'b1, SSIA_CTRL_OFS, 32'h0000_0003);
    clk_en <= 1'b1;
    apb(1'b0, SSIA_CTRL_OFS, 32'h0000_0000);
    chk("frozen", 32'h0000_0000, r32);
    $display("test tool and duplicate done");
    local_amps <= 5'h03;
    exp_amps <= 32'h0000_0042;
    repeat (4) @(posedge pclk);
    apb(1'b0, SSIA_UNIT_OFS, 32'h0000_0000);
    f = 1 + 3;
    u = 32'h0000_0000;
    for (int k = 0; k < 6; k++) begin
      u = u | (32'(f) << (5 * k));
      f += int'(exp_amps[4*k +: 4]);
    end
    chk("unit_nums", u, r32);
    apb(1'b0, SSIA_AMP_OFS, 32'h0000_0000);
    chk("amp_total", 32'(f - 1), r32);
    local_amps <= 5'h14;
    exp_amps <= 32'hFFFF_FFFF;
    repeat (4) @(posedge pclk);
    apb(1'b0, SSIA_AMP_OFS, 32'h0000_0000);
    chk("amp_cap", 32'(MAX_AMPS), r32);
    apb(1'b0, SSIA_UNIT_OFS, 32'h0000_0000);
    chk1("amp_over", 1'b1, r32[30]);
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk1("unmapped_err", 1'b1, er);
    chk("unmapped_data", 32'h0000_0000, r32);
    apb(1'b1, SSIA_ADDR_OFS, 32'h0000_03FF);
    apb(1'b0, SSIA_ADDR_OFS, 32'h0000_0000);
    chk("addr_ro", 32'h0000_007B, r32);
    $display("test numbering and bus done");
    do_reset(12'h000);
    chk1("zero_tool", 1'b1, addr_from_tool);
    chk("zero_addr", {22'h0, NODE_ADDR_DEFAULT}, {22'h0, node_addr});
    apb(1'b1, SSIA_CTRL_OFS, 32'h004D_0000);
    repeat (4) @(posedge pclk);
    chk("zero_tool_val", 32'h0000_004D, {22'h0, node_addr});
    do_reset(12'h998);
    chk1("bad_sw_halt", 1'b1, op_halt);
    apb(1'b0, SSIA_STAT_OFS, 32'h0000_0000);
    chk1("bad_sw_flag", 1'b1, r32[STAT_BADSW_BIT]);
    $display("test switch reset cases done");
    results;
  end
endmodule
